// [core/fbrl_defines.svh]
// constants for the flash burst read latency block
// Operation
// - latency 8: one wait per start offset
// - latency 7: offset minus one waits
// - latency 6: offset minus two waits
// - latency 5: offset minus three waits
// - latency 4: offset minus four waits
// - latency 3: offset minus five waits
// - one word per clock after crossing
// - address counter wraps to zero
// - burst ends only on host action
// - free bank crossing may add waits
// - busy bank halts, ready low, data held
// - ready marks initial and inserted waits
// - array read in aligned eight-word groups; here one word per array request, from the start address
// - data after rising edge, address advances
`ifndef FBRL_DEFINES_SVH
`define FBRL_DEFINES_SVH

`define FBRL_DATA_W 16
`define FBRL_GRP_OFS_W 3
`define FBRL_GROUP_WORDS 4'h8
`define FBRL_LAT_MIN 4'h3
`define FBRL_LAT_MAX 4'h8
`define FBRL_BANK_XING_WS 1
`define FBRL_FIFO_DEPTH 4
`define FBRL_EPOCH_RST 2'h0
`define FBRL_BUF_ENTRIES 2'h2

`endif

// [core/fbrl_pkg.sv]
// types shared by the flash burst read latency block
`include "fbrl_defines.svh"

package fbrl_pkg;

    typedef enum logic [2:0] {
        FBRL_IDLE,
        FBRL_INIT,
        FBRL_DATA,
        FBRL_GWAIT,
        FBRL_BWAIT,
        FBRL_HALT
    } fbrl_state_e;

    // one array word tagged with the burst it was fetched for
    typedef struct packed {
        logic [1:0] epoch;
        logic [`FBRL_DATA_W-1:0] data;
    } fbrl_word_s;

endpackage

// [core/fbrl_burst_read.sv]
// burst read sequencer: array prefetch on mclk, bus sequencing on the link clock
`timescale 1ns/10ps
`include "fbrl_defines.svh"

module fbrl_burst_read
    import fbrl_pkg::*;
#(
    parameter int unsigned ADDR_W = 24,
    parameter int unsigned BANK_BITS = 2,
    parameter int unsigned FIFO_DEPTH = `FBRL_FIFO_DEPTH,
    parameter int unsigned BANK_XING_WS = `FBRL_BANK_XING_WS
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic address_valid_n_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic hw_reset_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [3:0] cfg_latency_i,
    input wire logic [(1<<BANK_BITS)-1:0] bank_busy_i,
    output logic arr_req_o,
    output logic [ADDR_W-1:0] arr_addr_o,
    input wire logic arr_rvalid_i,
    input wire logic [`FBRL_DATA_W-1:0] arr_rdata_i,
    output logic [`FBRL_DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic rdy_o
);

    localparam int unsigned AW = $clog2(FIFO_DEPTH);
    localparam int unsigned PW = AW + 1;
    localparam int unsigned NB = 1 << BANK_BITS;

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [1:0] epoch_bin(input logic [1:0] g);
        return {g[1], g[1] ^ g[0]};
    endfunction

    function automatic logic [BANK_BITS-1:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: BANK_BITS];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // link domain reset and control crossings

    logic lrst_s1_r;
    logic lrst_s2_r;
    logic [3:0] lat_s1_r;
    logic [3:0] lat_s2_r;
    logic [NB-1:0] busy_s1_r;
    logic [NB-1:0] busy_s2_r;

    always_ff @(posedge link_clk_i) begin
        lrst_s1_r <= rst_n_i;
        lrst_s2_r <= lrst_s1_r;
    end

    // latency setting is quasi-static; bank busy is a level
    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            lat_s1_r <= `FBRL_LAT_MAX;
            lat_s2_r <= `FBRL_LAT_MAX;
            busy_s1_r <= '0;
            busy_s2_r <= '0;
        end else begin
            lat_s1_r <= cfg_latency_i;
            lat_s2_r <= lat_s1_r;
            busy_s1_r <= bank_busy_i;
            busy_s2_r <= busy_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // burst epoch: changes on every start and every termination

    logic [1:0] epoch_r;
    logic [1:0] epoch_gray_r;
    logic active_r;
    logic [ADDR_W-1:0] start_addr_r;
    logic abort;
    logic start;
    logic [1:0] epoch_inc;

    assign abort = ce_n_i || !hw_reset_n_i;
    assign start = !abort && !address_valid_n_i;
    assign epoch_inc = epoch_r + 2'h1;

    // gray copy moves on the same edge, so the core starts fetching a link cycle sooner
    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            epoch_r <= `FBRL_EPOCH_RST;
            epoch_gray_r <= `FBRL_EPOCH_RST;
            active_r <= 1'b0;
        end else if (start) begin
            epoch_r <= epoch_inc;
            epoch_gray_r <= epoch_inc ^ {1'b0, epoch_inc[1]};
            active_r <= 1'b1;
        end else if (abort && active_r) begin
            epoch_r <= epoch_inc;
            epoch_gray_r <= epoch_inc ^ {1'b0, epoch_inc[1]};
            active_r <= 1'b0;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            start_addr_r <= '0;
        end else begin
            if (start) begin
                start_addr_r <= addr_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core side: pick up burst starts and prefetch the array

    logic [1:0] ep_s1_r;
    logic [1:0] ep_s2_r;
    logic [1:0] ep_seen_r;
    logic act_s1_r;
    logic act_s2_r;
    logic arm_r;
    logic fetch_on_r;
    logic [1:0] fetch_ep_r;
    logic [ADDR_W-1:0] fetch_addr_r;
    logic out_r;
    logic [1:0] req_ep_r;
    logic issue;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ep_s1_r <= `FBRL_EPOCH_RST;
            ep_s2_r <= `FBRL_EPOCH_RST;
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
        end else begin
            ep_s1_r <= epoch_gray_r;
            ep_s2_r <= ep_s1_r;
            act_s1_r <= active_r;
            act_s2_r <= act_s1_r;
        end
    end

    // act one cycle after the epoch moves so the active level has settled
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ep_seen_r <= `FBRL_EPOCH_RST;
            arm_r <= 1'b0;
        end else begin
            ep_seen_r <= ep_s2_r;
            arm_r <= ep_s2_r != ep_seen_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fetch_on_r <= 1'b0;
            fetch_ep_r <= `FBRL_EPOCH_RST;
        end else if (arm_r) begin
            fetch_on_r <= act_s2_r;
            fetch_ep_r <= epoch_bin(ep_seen_r);
        end else if (!act_s2_r) begin
            fetch_on_r <= 1'b0;
        end
    end

    logic [1:0] buf_cnt_r;
    logic buf_in_ready;

    assign buf_in_ready = buf_cnt_r < `FBRL_BUF_ENTRIES;
    // one read in flight, and only when the buffer can take its answer
    assign issue = fetch_on_r && !arm_r && !out_r && (buf_cnt_r == 2'h0);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fetch_addr_r <= '0;
        end else if (arm_r) begin
            fetch_addr_r <= start_addr_r;
        end else if (issue) begin
            fetch_addr_r <= fetch_addr_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_r <= 1'b0;
            req_ep_r <= `FBRL_EPOCH_RST;
            arr_req_o <= 1'b0;
            arr_addr_o <= '0;
        end else begin
            arr_req_o <= issue;
            if (issue) begin
                out_r <= 1'b1;
                req_ep_r <= fetch_ep_r;
                arr_addr_o <= fetch_addr_r;
            end else if (arr_rvalid_i) begin
                out_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-entry buffer between the array answer and the crossing fifo

    fbrl_word_s buf_mem [2];
    logic buf_wr_r;
    logic buf_rd_r;
    logic buf_push;
    logic buf_pop;
    logic buf_out_valid;
    logic fifo_full;

    assign buf_push = arr_rvalid_i && buf_in_ready;
    assign buf_out_valid = buf_cnt_r != 2'h0;
    assign buf_pop = buf_out_valid && !fifo_full;

    always_ff @(posedge mclk_i) begin
        if (buf_push) begin
            buf_mem[buf_wr_r] <= '{epoch: req_ep_r, data: arr_rdata_i};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            buf_wr_r <= 1'b0;
            buf_rd_r <= 1'b0;
            buf_cnt_r <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_wr_r <= !buf_wr_r;
            end
            if (buf_pop) begin
                buf_rd_r <= !buf_rd_r;
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gray pointer fifo from mclk to the link clock

    fbrl_word_s fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wbin_r;
    logic [PW-1:0] wgray_r;
    logic [PW-1:0] rgray_s1_r;
    logic [PW-1:0] rgray_s2_r;
    logic [PW-1:0] rbin_r;
    logic [PW-1:0] rgray_r;
    logic [PW-1:0] wgray_s1_r;
    logic [PW-1:0] wgray_s2_r;

    assign fifo_full = wgray_r == {~rgray_s2_r[PW-1:PW-2], rgray_s2_r[PW-3:0]};

    always_ff @(posedge mclk_i) begin
        if (buf_pop) begin
            fifo_mem[wbin_r[AW-1:0]] <= buf_mem[buf_rd_r];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wbin_r <= '0;
            wgray_r <= '0;
            rgray_s1_r <= '0;
            rgray_s2_r <= '0;
        end else begin
            rgray_s1_r <= rgray_r;
            rgray_s2_r <= rgray_s1_r;
            if (buf_pop) begin
                wbin_r <= wbin_r + 1'b1;
                wgray_r <= bin2gray(wbin_r + 1'b1);
            end
        end
    end

    fbrl_word_s head;
    logic fifo_empty;
    logic stale;
    logic fresh;
    logic emit;

    assign fifo_empty = rgray_r == wgray_s2_r;
    assign head = fifo_mem[rbin_r[AW-1:0]];
    assign stale = !fifo_empty && (head.epoch != epoch_r);
    assign fresh = !fifo_empty && (head.epoch == epoch_r);

    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            rbin_r <= '0;
            rgray_r <= '0;
            wgray_s1_r <= '0;
            wgray_s2_r <= '0;
        end else begin
            wgray_s1_r <= wgray_r;
            wgray_s2_r <= wgray_s1_r;
            if (stale || emit) begin
                rbin_r <= rbin_r + 1'b1;
                rgray_r <= bin2gray(rbin_r + 1'b1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link sequencer: initial latency, group crossing and bank crossing waits

    fbrl_state_e state_r;
    logic [3:0] cnt_r;
    logic [2:0] extra_r;
    logic paid_r;
    logic [ADDR_W-1:0] laddr_r;
    logic [BANK_BITS-1:0] bank_r;
    logic [ADDR_W-1:0] next_addr;
    logic [3:0] lat;
    logic [3:0] grp_sum;
    logic shown_r;

    assign lat = (lat_s2_r < `FBRL_LAT_MIN) ? `FBRL_LAT_MIN :
                 (lat_s2_r > `FBRL_LAT_MAX) ? `FBRL_LAT_MAX : lat_s2_r;
    // waits before the first group crossing: offset + latency - 8, floored at zero
    assign grp_sum = {1'b0, addr_i[`FBRL_GRP_OFS_W-1:0]} + lat;
    assign next_addr = laddr_r + 1'b1;
    assign emit = (state_r == FBRL_DATA) && fresh;

    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            state_r <= FBRL_IDLE;
            cnt_r <= 4'h0;
            extra_r <= 3'h0;
            paid_r <= 1'b0;
            laddr_r <= '0;
            bank_r <= '0;
        end else if (abort) begin
            state_r <= FBRL_IDLE;
        end else if (start) begin
            state_r <= FBRL_INIT;
            cnt_r <= lat - 4'h1;
            laddr_r <= addr_i;
            bank_r <= bank_of(addr_i);
            paid_r <= 1'b0;
            extra_r <= (grp_sum > `FBRL_GROUP_WORDS) ? 3'(grp_sum - `FBRL_GROUP_WORDS) : 3'h0;
        end else begin
            unique case (state_r)
                FBRL_IDLE: begin
                end
                FBRL_INIT: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_r <= FBRL_DATA;
                    end
                end
                FBRL_DATA: begin
                    if (emit) begin
                        laddr_r <= next_addr;
                        bank_r <= bank_of(laddr_r);
                        if ((next_addr[`FBRL_GRP_OFS_W-1:0] == '0) && !paid_r) begin
                            paid_r <= 1'b1;
                        end
                        // a crossing with no group waits still pays its bank waits
                        if ((next_addr[`FBRL_GRP_OFS_W-1:0] == '0) && !paid_r
                            && (extra_r != 3'h0)) begin
                            state_r <= FBRL_GWAIT;
                            cnt_r <= {1'b0, extra_r};
                        end else if (bank_of(next_addr) != bank_of(laddr_r)) begin
                            if (busy_s2_r[bank_of(next_addr)]) begin
                                state_r <= FBRL_HALT;
                            end else if (BANK_XING_WS != 0) begin
                                state_r <= FBRL_BWAIT;
                                cnt_r <= 4'(BANK_XING_WS);
                            end
                        end
                    end
                end
                FBRL_GWAIT: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        if (bank_of(laddr_r) == bank_r) begin
                            state_r <= FBRL_DATA;
                        end else if (busy_s2_r[bank_of(laddr_r)]) begin
                            state_r <= FBRL_HALT;
                        end else if (BANK_XING_WS != 0) begin
                            state_r <= FBRL_BWAIT;
                            cnt_r <= 4'(BANK_XING_WS);
                        end else begin
                            state_r <= FBRL_DATA;
                        end
                    end
                end
                FBRL_BWAIT: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_r <= FBRL_DATA;
                    end
                end
                FBRL_HALT: begin
                    if (!busy_s2_r[bank_of(laddr_r)]) begin
                        state_r <= FBRL_DATA;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus outputs: ready only with a word, data held through every wait

    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            rdy_o <= 1'b0;
            dq_o <= '0;
            shown_r <= 1'b0;
        end else begin
            rdy_o <= emit && !abort && !start;
            if (emit && !abort && !start) begin
                dq_o <= head.data;
            end
            if (abort || start) begin
                shown_r <= 1'b0;
            end else if (emit) begin
                shown_r <= 1'b1;
            end
        end
    end

    // output enable follows the bus; it never stops the burst
    always_ff @(posedge link_clk_i) begin
        if (!lrst_s2_r) begin
            dq_oe_o <= 1'b0;
        end else begin
            dq_oe_o <= !abort && !start && !oe_n_i && (shown_r || emit);
        end
    end

endmodule // fbrl_burst_read

// [verification/fbrl_burst_read_asserts.sv]
// port assertions for the burst read sequencer
`timescale 1ns/10ps
`include "fbrl_defines.svh"

module fbrl_burst_read_chk
    import fbrl_pkg::*;
#(
    parameter int unsigned BANK_BITS = 2
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic address_valid_n_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic hw_reset_n_i,
    input wire logic [(1<<BANK_BITS)-1:0] bank_busy_i,
    input wire logic arr_req_o,
    input wire logic arr_rvalid_i,
    input wire logic [`FBRL_DATA_W-1:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic rdy_o
);
    logic pend_r;

    // one array read in flight at a time
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pend_r <= 1'b0;
        end else if (arr_req_o) begin
            pend_r <= 1'b1;
        end else if (arr_rvalid_i) begin
            pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////
    sequence s_word_gap;
        rdy_o && !ce_n_i && hw_reset_n_i && address_valid_n_i ##1 !rdy_o;
    endsequence

    sequence s_start;
        !address_valid_n_i && !ce_n_i && hw_reset_n_i;
    endsequence

    end_ce_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        ce_n_i |=> !rdy_o) else $error("ready after chip enable high");
    end_rst_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !hw_reset_n_i |=> !rdy_o) else $error("ready after hardware reset");
    init_wait_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        s_start |=> !rdy_o [*2]) else $error("word before initial latency");
    hold_dq_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        s_word_gap |-> $stable(dq_o)) else $error("data moved in a wait cycle");
    burst_live_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        rdy_o |-> ##[1:10] (rdy_o || ce_n_i || !hw_reset_n_i || !address_valid_n_i
        || (|bank_busy_i))) else $error("burst stopped by itself");
    oe_off_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        oe_n_i |=> !dq_oe_o) else $error("driving with output enable high");
    one_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        arr_req_o |-> !pend_r) else $error("second array read in flight");
    req_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        arr_req_o |=> !arr_req_o) else $error("array request too long");
endmodule // fbrl_burst_read_chk

bind fbrl_burst_read fbrl_burst_read_chk #(.BANK_BITS(BANK_BITS)) u_chk (
    .mclk_i, .rst_n_i, .link_clk_i, .address_valid_n_i, .ce_n_i, .oe_n_i,
    .hw_reset_n_i, .bank_busy_i, .arr_req_o, .arr_rvalid_i, .dq_o, .dq_oe_o, .rdy_o
);

// [verification/fbrl_array_model.sv]
// array model answering the sequencer's reads, fast or slow
`timescale 1ns/10ps

module fbrl_array_model
    import fbrl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic [5:0] addr_i,
    output logic rvalid_o,
    output logic [15:0] rdata_o
);
    logic [3:0] cnt_r;
    logic [5:0] addr_r;

    always_ff @(posedge mclk_i) begin
        rvalid_o <= 1'b0;
        // outside a valid cycle the data lines alternate between the inverse of the last word and the last word
        rdata_o <= ~rdata_o;
        if (!rst_n_i) begin
            cnt_r <= 4'h0;
            rdata_o <= 16'h0000;
        end else if (req_i) begin
            addr_r <= addr_i;
            cnt_r <= slow_i ? 4'h6 : 4'h1;
        end else if (cnt_r == 4'h1) begin
            cnt_r <= 4'h0;
            rvalid_o <= 1'b1;
            rdata_o <= 16'hA500 ^ {10'h000, addr_r};
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule // fbrl_array_model

// [verification/tb_top.sv]
// self-checking bench for the burst read sequencer
`timescale 1ns/10ps

module tb_top;
    import fbrl_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic lk = 1'b0;
    logic lk_en = 1'b1;
    logic av_n = 1'b1;
    logic ce_n = 1'b1;
    logic oe_n = 1'b0;
    logic hr_n = 1'b1;
    logic slow = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [3:0] lat = 4'h8;
    logic [3:0] busy = 4'h0;
    logic req, rv, oe, rdy;
    logic [5:0] aa;
    logic [15:0] rd, dq;
    int error_cnt = 0;
    int n_compared = 0;
    int eidx[16];
    logic [15:0] dat[16];

    fbrl_burst_read #(.ADDR_W(6)) DUT (
        .mclk_i, .rst_n_i, .link_clk_i(lk), .address_valid_n_i(av_n), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .hw_reset_n_i(hr_n), .addr_i(addr), .cfg_latency_i(lat),
        .bank_busy_i(busy), .arr_req_o(req), .arr_addr_o(aa), .arr_rvalid_i(rv),
        .arr_rdata_i(rd), .dq_o(dq), .dq_oe_o(oe), .rdy_o(rdy)
    );
    fbrl_array_model ARR (.mclk_i, .rst_n_i, .slow_i(slow), .req_i(req),
        .addr_i(aa), .rvalid_o(rv), .rdata_o(rd));

    initial forever #5 mclk_i = ~mclk_i;
    // link clock parks low between bursts
    initial begin
        #3;
        forever #62.5 if (lk_en || lk) lk = ~lk;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic quit;
        lk_en = 1'b1;
        @(posedge lk) ce_n <= 1'b1;
        repeat (3) @(posedge lk);
        lk_en = 1'b0;
    endtask

    task automatic go(input logic [5:0] a);
        lk_en = 1'b1;
        @(posedge lk) begin
            av_n <= 1'b0;
            ce_n <= 1'b0;
            addr <= a;
        end
        @(posedge lk) av_n <= 1'b1;
    endtask

    // edge index after the start and data of each delivered word
    task automatic grab(input int n);
        int k;
        int j;
        k = 0;
        j = 0;
        while (j < n && k < 40) begin
            @(negedge lk);
            if (rdy === 1'b1) begin
                eidx[j] = k;
                dat[j] = dq;
                j++;
            end
            k++;
        end
        if (j < n) begin
            chk(16'(j), 16'(n));
            conclude();
        end
    endtask

    task automatic still(input int n);
        repeat (n) begin
            @(negedge lk);
            chk({15'h0000, rdy}, 16'h0000);
        end
    endtask

    ////////////////////////////////////////
    task automatic t_lat;
        int w;
        int e;
        for (int l = 3; l <= 8; l++) begin
            for (int o = 0; o < 8; o++) begin
                @(posedge mclk_i) lat <= 4'(l);
                quit();
                go(6'(o));
                grab(9);
                w = (o + l > 8) ? o + l - 8 : 0;
                for (int j = 0; j < 9; j++) begin
                    e = l + j + ((o + j >= 8) ? w : 0);
                    chk(16'(eidx[j]), 16'(e));
                    chk(dat[j], 16'hA500 ^ 16'(o + j));
                end
            end
        end
        $display("latency table test done");
    endtask

    task automatic t_wrap;
        @(posedge mclk_i) lat <= 4'h3;
        quit();
        go(6'h3C);
        grab(6);
        for (int j = 0; j < 6; j++) begin
            chk(16'(eidx[j]), 16'(3 + j + (j >= 4 ? 1 : 0)));
            chk(dat[j], 16'hA500 ^ 16'((60 + j) % 64));
        end
        $display("wrap test done");
    endtask

    task automatic t_halt;
        @(posedge mclk_i) busy <= 4'h2;
        quit();
        go(6'h0E);
        grab(2);
        chk(dat[1], 16'hA50F);
        repeat (6) begin
            @(negedge lk);
            chk({15'h0000, rdy}, 16'h0000);
            chk(dq, 16'hA50F);
        end
        @(posedge mclk_i) busy <= 4'h0;
        grab(1);
        chk(dat[0], 16'hA510);
        $display("busy bank test done");
    endtask

    task automatic t_end;
        @(posedge mclk_i) begin
            lat <= 4'h8;
            slow <= 1'b1;
        end
        quit();
        go(6'h00);
        grab(3);
        chk({15'h0000, oe}, 16'h0001);
        @(posedge lk) oe_n <= 1'b1;
        grab(3);
        chk(dat[2], 16'hA505);
        chk({15'h0000, oe}, 16'h0000);
        go(6'h20);
        grab(1);
        chk(16'(eidx[0]), 16'h0008);
        chk(dat[0], 16'hA520);
        @(posedge lk) hr_n <= 1'b0;
        @(posedge lk) hr_n <= 1'b1;
        still(4);
        go(6'h05);
        grab(2);
        @(posedge lk) ce_n <= 1'b1;
        @(posedge lk);
        still(4);
        @(posedge lk) oe_n <= 1'b0;
        $display("termination test done");
    endtask

    initial begin
        repeat (4) @(posedge lk);
        @(posedge mclk_i) rst_n_i <= 1'b1;
        repeat (2) @(posedge lk);
        t_lat();
        t_wrap();
        t_halt();
        t_end();
        conclude();
    end
endmodule // tb_top
